// *** core/adc_exec.sv ***
// Executor for converter, comparator, power-off and watchdog instructions.
`timescale 1ns/10ps
// Timing in short: an instruction is taken on the rising edge at which
// instr_valid is high and the block is not in back-up. Every effect of it,
// register writes, pulses and flag updates, shows at that same edge and the
// pulses last exactly one cycle.
// The executor only signals a skip; the sequencer outside decides what
// a skip means for the program counter, so no fetch logic lives here.
// The two arming instructions are consumed by whatever instruction is
// taken next, so a single stray instruction between arm and use disarms.
// Converter events, and watchdog events while watchdog_stopped is low, are level inputs sampled on every edge;
// an event and a clearing instruction in the same cycle leave the flag set,
// because losing a completion would hang polling firmware.
// Back-up is left only through reset, which also restores all state.
`include "adc_exec_cfg.svh"
module adc_exec #(
	parameter bit HIGH_VOLTAGE_VARIANT = 1'b1,
	parameter int RESULT_WIDTH = 10
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	// One-cycle strobe: instr_code holds an instruction to execute.
	input wire logic instr_valid,
	input wire logic [9:0] instr_code,
	input wire logic [3:0] reg_a,
	input wire logic [3:0] reg_b,
	input wire logic [9:0] ad_result,
	input wire logic [3:0] interrupt_control_reg_two,
	input wire logic conv_done_event,
	input wire logic watchdog_timeout_event,
	input wire logic power_down_flag,
	output logic [3:0] reg_a_wdata,
	output logic reg_a_we,
	output logic [3:0] reg_b_wdata,
	output logic reg_b_we,
	output logic pc_advance,
	output logic skip_next,
	output logic instr_taken,
	output logic [3:0] converter_control_reg,
	output logic [7:0] comparator_reg,
	output logic conversion_mode_select,
	output logic adc_start,
	output logic comparator_start,
	output logic conversion_done_flag,
	output logic watchdog_flag,
	output logic watchdog_stopped,
	output logic upper_bit_ref_enable,
	output logic ram_backup,
	output logic drop_detect_enable
);

	initial begin
		if (RESULT_WIDTH != 10) begin
			$error("adc_exec serves a 10-bit conversion result only.");
		end
	end

	// Picks one nibble of a byte; used for both comparator halves.
	function automatic logic [3:0] nibble_of(input logic [7:0] v, input logic hi);
		nibble_of = hi ? v[7:4] : v[3:0];
	endfunction : nibble_of

	adc_exec_pkg::op_t op;

	instr_decode u_decode (
		.code(instr_code),
		.op(op)
	);

	// Run state and the programmer-visible converter registers.
	adc_exec_pkg::run_state_t state_q;
	adc_exec_pkg::run_state_t state_d;
	logic [3:0] ctrl_q;
	logic [3:0] ctrl_d;
	logic [7:0] cmp_q;
	logic [7:0] cmp_d;
	logic done_q;
	logic done_d;
	logic wdf_q;
	logic wdf_d;
	logic wdt_stop_q;
	logic wdt_stop_d;
	logic upt_q;
	logic upt_d;
	logic detect_en_q;
	logic detect_en_d;

	// Arms remember only the instruction just taken.
	logic pof_armed_q;
	logic pof_armed_d;
	logic wdt_armed_q;
	logic wdt_armed_d;

	// Write-back and sequencer pulses, registered so they leave on a clean edge.
	logic [3:0] a_q;
	logic [3:0] a_d;
	logic a_we_q;
	logic a_we_d;
	logic [3:0] b_q;
	logic [3:0] b_d;
	logic b_we_q;
	logic b_we_d;
	logic pc_q;
	logic pc_d;
	logic skip_q;
	logic skip_d;
	logic taken_q;
	logic taken_d;
	logic adc_start_q;
	logic adc_start_d;
	logic cmp_start_q;
	logic cmp_start_d;

	logic cmp_mode;
	logic irq_en;
	logic exec;

	assign cmp_mode = ctrl_q[`MODE_SEL_BIT];
	assign irq_en = interrupt_control_reg_two[`IRQ_EN_BIT];
	// Nothing executes once the back-up state is entered; only reset leaves it.
	assign exec = instr_valid && (state_q == adc_exec_pkg::ST_RUN);

	always_comb begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		cmp_d = cmp_q;
		done_d = done_q;
		wdf_d = wdf_q;
		wdt_stop_d = wdt_stop_q;
		upt_d = upt_q;
		detect_en_d = detect_en_q;
		pof_armed_d = pof_armed_q;
		wdt_armed_d = wdt_armed_q;
		a_d = a_q;
		a_we_d = 1'b0;
		b_d = b_q;
		b_we_d = 1'b0;
		pc_d = 1'b0;
		skip_d = 1'b0;
		taken_d = 1'b0;
		adc_start_d = 1'b0;
		cmp_start_d = 1'b0;
		if (exec) begin
			taken_d = 1'b1;
			pc_d = 1'b1;
			// Any executed instruction consumes both arms.
			pof_armed_d = 1'b0;
			wdt_armed_d = 1'b0;
			case (op)
				adc_exec_pkg::OP_NOP: begin
					pc_d = 1'b1;
				end
				adc_exec_pkg::OP_RESULT_READ: begin
					a_we_d = 1'b1;
					b_we_d = 1'b1;
					if (cmp_mode) begin
						b_d = nibble_of(cmp_q, 1'b1);
						a_d = nibble_of(cmp_q, 1'b0);
					end else begin
						b_d = ad_result[9:6];
						a_d = ad_result[5:2];
					end
				end
				adc_exec_pkg::OP_LOW_READ: begin
					a_we_d = 1'b1;
					a_d = {ad_result[1:0], 1'b0, 1'b0};
				end
				adc_exec_pkg::OP_CMP_LOAD: begin
					if (cmp_mode) begin
						cmp_d = {reg_b, reg_a};
					end
				end
				adc_exec_pkg::OP_CTRL_READ: begin
					a_we_d = 1'b1;
					a_d = ctrl_q;
				end
				adc_exec_pkg::OP_CTRL_WRITE: begin
					ctrl_d = reg_a;
				end
				adc_exec_pkg::OP_CONV_START: begin
					done_d = 1'b0;
					adc_start_d = !cmp_mode;
					cmp_start_d = cmp_mode;
				end
				adc_exec_pkg::OP_DONE_TEST: begin
					if (!irq_en && done_q) begin
						done_d = 1'b0;
						skip_d = 1'b1;
					end
					// With the converter interrupt enabled the flag belongs to
					// the interrupt logic and is left alone.
				end
				adc_exec_pkg::OP_POWER_ARM: begin
					pof_armed_d = 1'b1;
				end
				adc_exec_pkg::OP_POWER_OFF: begin
					if (pof_armed_q) begin
						state_d = adc_exec_pkg::ST_BACKUP;
					end
					// Unarmed, it just advances the counter.
				end
				adc_exec_pkg::OP_POWER_TEST: begin
					skip_d = power_down_flag;
				end
				adc_exec_pkg::OP_WDT_ARM: begin
					wdt_armed_d = 1'b1;
				end
				adc_exec_pkg::OP_WDT_RESTART: begin
					if (wdf_q) begin
						wdf_d = 1'b0;
						skip_d = 1'b1;
					end
					if (wdt_armed_q) begin
						wdt_stop_d = 1'b1;
					end
				end
				adc_exec_pkg::OP_REF_CLEAR: begin
					upt_d = 1'b0;
				end
				adc_exec_pkg::OP_REF_SET: begin
					upt_d = 1'b1;
				end
				adc_exec_pkg::OP_DETECT_EN: begin
					// The low-voltage variant has no detector to arm.
					if (HIGH_VOLTAGE_VARIANT) begin
						detect_en_d = 1'b1;
					end
				end
				default: begin
					pc_d = 1'b1;
				end
			endcase
		end
		// Hardware events win over a clear in the same cycle, so a completion
		// or a timeout while the watchdog is not stopped landing on the test instruction is never lost.
		if (conv_done_event) begin
			done_d = 1'b1;
		end
		if (watchdog_timeout_event && !wdt_stop_q) begin
			wdf_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= adc_exec_pkg::ST_RUN;
			ctrl_q <= `CTRL_RESET;
			cmp_q <= `CMP_RESET;
			done_q <= 1'b0;
			wdf_q <= 1'b0;
			wdt_stop_q <= 1'b0;
			upt_q <= 1'b0;
			detect_en_q <= 1'b0;
			pof_armed_q <= 1'b0;
			wdt_armed_q <= 1'b0;
			a_q <= 4'h0;
			a_we_q <= 1'b0;
			b_q <= 4'h0;
			b_we_q <= 1'b0;
			pc_q <= 1'b0;
			skip_q <= 1'b0;
			taken_q <= 1'b0;
			adc_start_q <= 1'b0;
			cmp_start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			cmp_q <= cmp_d;
			done_q <= done_d;
			wdf_q <= wdf_d;
			wdt_stop_q <= wdt_stop_d;
			upt_q <= upt_d;
			detect_en_q <= detect_en_d;
			pof_armed_q <= pof_armed_d;
			wdt_armed_q <= wdt_armed_d;
			a_q <= a_d;
			a_we_q <= a_we_d;
			b_q <= b_d;
			b_we_q <= b_we_d;
			pc_q <= pc_d;
			skip_q <= skip_d;
			taken_q <= taken_d;
			adc_start_q <= adc_start_d;
			cmp_start_q <= cmp_start_d;
		end
	end

	assign reg_a_wdata = a_q;
	assign reg_a_we = a_we_q;
	assign reg_b_wdata = b_q;
	assign reg_b_we = b_we_q;
	assign pc_advance = pc_q;
	assign skip_next = skip_q;
	assign instr_taken = taken_q;
	assign converter_control_reg = ctrl_q;
	assign comparator_reg = cmp_q;
	assign conversion_mode_select = cmp_mode;
	assign adc_start = adc_start_q;
	assign comparator_start = cmp_start_q;
	assign conversion_done_flag = done_q;
	assign watchdog_flag = wdf_q;
	assign watchdog_stopped = wdt_stop_q;
	assign upper_bit_ref_enable = upt_q;
	assign ram_backup = (state_q == adc_exec_pkg::ST_BACKUP);
	// The detector itself sits outside; this level only tells it to watch in back-up.
	assign drop_detect_enable = detect_en_q;

endmodule : adc_exec

// *** core/adc_exec_cfg.svh ***
// Constants for the converter and system instruction executor.
`ifndef ADC_EXEC_CFG_SVH
`define ADC_EXEC_CFG_SVH

`define OPC_NOP 10'h000
`define OPC_POWER_OFF 10'h002
`define OPC_POWER_TEST 10'h003
`define OPC_REF_CLEAR 10'h058
`define OPC_REF_SET 10'h059
`define OPC_POWER_ARM 10'h05B
`define OPC_CTRL_WRITE 10'h204
`define OPC_CMP_LOAD 10'h239
`define OPC_CTRL_READ 10'h244
`define OPC_LOW_READ 10'h249
`define OPC_RESULT_READ 10'h279
`define OPC_DONE_TEST 10'h287
`define OPC_DETECT_EN 10'h293
`define OPC_WDT_ARM 10'h29C
`define OPC_CONV_START 10'h29F
`define OPC_WDT_RESTART 10'h2A0

`define MODE_SEL_BIT 3
`define IRQ_EN_BIT 2
`define CTRL_RESET 4'h0
`define CMP_RESET 8'h00

`endif

// *** core/adc_exec_pkg.sv ***
// Types shared by the executor and its opcode decoder.
package adc_exec_pkg;
	typedef enum logic [4:0] {
		OP_OTHER = 5'h00,
		OP_NOP = 5'h01,
		OP_POWER_OFF = 5'h02,
		OP_POWER_ARM = 5'h03,
		OP_POWER_TEST = 5'h04,
		OP_REF_CLEAR = 5'h05,
		OP_REF_SET = 5'h06,
		OP_CTRL_WRITE = 5'h07,
		OP_CMP_LOAD = 5'h08,
		OP_CTRL_READ = 5'h09,
		OP_LOW_READ = 5'h0A,
		OP_RESULT_READ = 5'h0B,
		OP_DONE_TEST = 5'h0C,
		OP_DETECT_EN = 5'h0D,
		OP_WDT_ARM = 5'h0E,
		OP_CONV_START = 5'h0F,
		OP_WDT_RESTART = 5'h10
	} op_t;

	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_BACKUP = 1'b1
	} run_state_t;
endpackage : adc_exec_pkg

// *** core/instr_decode.sv ***
// Opcode decoder for the converter and system instruction group.
`timescale 1ns/10ps
`include "adc_exec_cfg.svh"
module instr_decode (
	input wire logic [9:0] code,
	output adc_exec_pkg::op_t op
);
	always_comb begin
		case (code)
			`OPC_NOP: op = adc_exec_pkg::OP_NOP;
			`OPC_POWER_OFF: op = adc_exec_pkg::OP_POWER_OFF;
			`OPC_POWER_ARM: op = adc_exec_pkg::OP_POWER_ARM;
			`OPC_POWER_TEST: op = adc_exec_pkg::OP_POWER_TEST;
			`OPC_REF_CLEAR: op = adc_exec_pkg::OP_REF_CLEAR;
			`OPC_REF_SET: op = adc_exec_pkg::OP_REF_SET;
			`OPC_CTRL_WRITE: op = adc_exec_pkg::OP_CTRL_WRITE;
			`OPC_CMP_LOAD: op = adc_exec_pkg::OP_CMP_LOAD;
			`OPC_CTRL_READ: op = adc_exec_pkg::OP_CTRL_READ;
			`OPC_LOW_READ: op = adc_exec_pkg::OP_LOW_READ;
			`OPC_RESULT_READ: op = adc_exec_pkg::OP_RESULT_READ;
			`OPC_DONE_TEST: op = adc_exec_pkg::OP_DONE_TEST;
			`OPC_DETECT_EN: op = adc_exec_pkg::OP_DETECT_EN;
			`OPC_WDT_ARM: op = adc_exec_pkg::OP_WDT_ARM;
			`OPC_CONV_START: op = adc_exec_pkg::OP_CONV_START;
			`OPC_WDT_RESTART: op = adc_exec_pkg::OP_WDT_RESTART;
			default: op = adc_exec_pkg::OP_OTHER;
		endcase
	end
endmodule : instr_decode

// *** verification/periph_model.sv ***
// Converter and watchdog stand-in on the far side of the executor.
`timescale 1ns/10ps
module periph_model #(
	parameter int CONV_CYCLES = 3
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic adc_start,
	input wire logic comparator_start,
	input wire logic watchdog_stopped,
	input wire logic wdt_expire,
	output logic conv_done_event,
	output logic watchdog_timeout_event
);
	int cnt_q;
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 0;
			conv_done_event <= 1'b0;
			watchdog_timeout_event <= 1'b0;
		end else begin
			if (adc_start || comparator_start) cnt_q <= CONV_CYCLES;
			else if (cnt_q != 0) cnt_q <= cnt_q - 1;
			conv_done_event <= (cnt_q == 1);
			// A stopped watchdog no longer counts, so it never times out again.
			watchdog_timeout_event <= wdt_expire && !watchdog_stopped;
		end
	end
endmodule : periph_model

// *** verification/adc_exec_checker.sv ***
// Concurrent checks on the executor's ports.
`timescale 1ns/10ps
`include "adc_exec_cfg.svh"
module adc_exec_checker (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [9:0] instr_code,
	input wire logic [3:0] reg_a,
	input wire logic [3:0] reg_b,
	input wire logic [9:0] ad_result,
	input wire logic conv_done_event,
	input wire logic power_down_flag,
	input wire logic [3:0] reg_a_wdata,
	input wire logic [3:0] reg_b_wdata,
	input wire logic reg_b_we,
	input wire logic skip_next,
	input wire logic instr_taken,
	input wire logic [3:0] converter_control_reg,
	input wire logic [7:0] comparator_reg,
	input wire logic conversion_mode_select,
	input wire logic adc_start,
	input wire logic comparator_start,
	input wire logic conversion_done_flag,
	input wire logic ram_backup
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic t;
	logic [9:0] r_q;
	logic [3:0] a_q;
	logic [3:0] b_q;
	assign t = instr_valid && !ram_backup;
	always_ff @(posedge ref_clk) begin
		r_q <= ad_result;
		a_q <= reg_a;
		b_q <= reg_b;
	end
	a_mode_bit: assert property (conversion_mode_select == converter_control_reg[3])
		else $error("mode select differs from control bit");
	a_start_op: assert property (t && instr_code == `OPC_CONV_START && !conv_done_event |=>
		!conversion_done_flag && comparator_start == $past(conversion_mode_select)
		&& adc_start != comparator_start) else $error("start wrong");
	a_result_read: assert property (t && instr_code == `OPC_RESULT_READ && !conversion_mode_select
		|=> reg_b_we && reg_b_wdata == r_q[9:6] && reg_a_wdata == r_q[5:2])
		else $error("result read wrong");
	a_low_read: assert property (t && instr_code == `OPC_LOW_READ |=>
		reg_a_wdata == {r_q[1:0], 2'b00}) else $error("low read wrong");
	a_cmp_load: assert property (t && instr_code == `OPC_CMP_LOAD |=> comparator_reg ==
		($past(conversion_mode_select) ? {b_q, a_q} : $past(comparator_reg)))
		else $error("comparator load wrong");
	a_pof_armed: assert property (t && instr_code == `OPC_POWER_ARM ##1
		t && instr_code == `OPC_POWER_OFF
		|=> ram_backup) else $error("armed power-off ignored");
	a_backup_holds: assert property (ram_backup |=> ram_backup && !instr_taken)
		else $error("back-up left or instruction taken");
	a_power_test: assert property (t && instr_code == `OPC_POWER_TEST |=>
		skip_next == $past(power_down_flag)) else $error("power test skip wrong");
	c_start: cover property (t && instr_code == `OPC_CONV_START);
	c_backup: cover property ($rose(ram_backup));
	c_cmp: cover property (t && instr_code == `OPC_CMP_LOAD && conversion_mode_select);
endmodule : adc_exec_checker

// *** verification/adc_and_system_instr_exec_test.sv ***
// Self-checking bench for the converter and system instruction executor.
`timescale 1ns/10ps
`include "adc_exec_cfg.svh"
module adc_and_system_instr_exec_test;
	typedef struct packed {
		logic [9:0] c;
		logic [3:0] a;
		logic p;
		logic [3:0] ea;
		logic [3:0] eb;
		logic wa;
		logic wb;
		logic sk;
	} row_t;
	logic ref_clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, power_down_flag = 1'b0;
	logic wdt_expire = 1'b0;
	logic [9:0] instr_code = 10'h000, ad_result = 10'h2D6;
	logic [3:0] reg_a = 4'h0, reg_b = 4'h0, interrupt_control_reg_two = 4'h0;
	logic [3:0] reg_a_wdata, reg_b_wdata, converter_control_reg;
	logic [7:0] comparator_reg;
	logic reg_a_we, reg_b_we, pc_advance, skip_next, instr_taken, conversion_mode_select;
	logic adc_start, comparator_start, conversion_done_flag, watchdog_flag, watchdog_stopped;
	logic upper_bit_ref_enable, ram_backup, drop_detect_enable;
	logic conv_done_event, watchdog_timeout_event;
	int err_count = 0, checks = 0;
	// Result 2D6 splits into B, 5, and low bits 10; a control write of 3 reads back 3.
	localparam row_t rows [8] = '{
		'{`OPC_CTRL_WRITE, 4'h3, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0},
		'{`OPC_CTRL_READ, 4'h0, 1'b0, 4'h3, 4'h0, 1'b1, 1'b0, 1'b0},
		'{`OPC_RESULT_READ, 4'h0, 1'b0, 4'h5, 4'hB, 1'b1, 1'b1, 1'b0},
		'{`OPC_LOW_READ, 4'hF, 1'b0, 4'h8, 4'h0, 1'b1, 1'b0, 1'b0},
		'{`OPC_POWER_TEST, 4'h0, 1'b1, 4'h0, 4'h0, 1'b0, 1'b0, 1'b1},
		'{`OPC_POWER_TEST, 4'h0, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0},
		'{`OPC_NOP, 4'hF, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0},
		'{`OPC_POWER_OFF, 4'h0, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0}};
	adc_exec DUT (.*);
	periph_model model_i (.*);
	always #50 ref_clk = ~ref_clk;
	task automatic ck(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: mismatch at check %0d", $time, checks);
		end
	endtask : ck
	// Valid stays high on return so that back-to-back calls issue one per cycle.
	task automatic ex(input logic [9:0] c, input logic [3:0] a = 4'h0, input logic [3:0] b = 4'h0);
		instr_code = c;
		reg_a = a;
		reg_b = b;
		instr_valid = 1'b1;
		@(posedge ref_clk);
		#5;
	endtask : ex
	task automatic idle(input int n);
		instr_valid = 1'b0;
		repeat (n) @(posedge ref_clk);
		#5;
	endtask : idle
	task automatic summarize;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		#100000;
		err_count++;
		summarize;
	end
	initial begin
		idle(16);
		rst_b = 1'b1;
		foreach (rows[i]) begin
			power_down_flag = rows[i].p;
			ex(rows[i].c, rows[i].a);
			ck(pc_advance === 1'b1 && instr_taken === 1'b1 && ram_backup === 1'b0
				&& skip_next === rows[i].sk && reg_a_we === rows[i].wa && reg_b_we === rows[i].wb
				&& (!rows[i].wa || reg_a_wdata === rows[i].ea)
				&& (!rows[i].wb || reg_b_wdata === rows[i].eb));
		end
		ex(`OPC_CTRL_WRITE, 4'h8);
		ck(conversion_mode_select === 1'b1);
		ex(`OPC_CMP_LOAD, 4'h4, 4'hC);
		ck(comparator_reg === 8'hC4);
		ex(`OPC_RESULT_READ);
		ck(reg_b_wdata === 4'hC && reg_a_wdata === 4'h4);
		ex(`OPC_CONV_START);
		ck(comparator_start === 1'b1 && adc_start === 1'b0 && conversion_done_flag === 1'b0);
		interrupt_control_reg_two = 4'h4;
		idle(6);
		ex(`OPC_DONE_TEST);
		ck(skip_next === 1'b0 && conversion_done_flag === 1'b1);
		interrupt_control_reg_two = 4'h0;
		ex(`OPC_DONE_TEST);
		ck(skip_next === 1'b1 && conversion_done_flag === 1'b0);
		ex(`OPC_DONE_TEST);
		ck(skip_next === 1'b0);
		ex(`OPC_CTRL_WRITE);
		ex(`OPC_CMP_LOAD, 4'h1, 4'h1);
		ck(comparator_reg === 8'hC4);
		ex(`OPC_CONV_START);
		ck(adc_start === 1'b1 && comparator_start === 1'b0);
		ex(`OPC_REF_SET);
		ck(upper_bit_ref_enable === 1'b1);
		ex(`OPC_REF_CLEAR);
		ck(upper_bit_ref_enable === 1'b0);
		ex(`OPC_DETECT_EN);
		ck(drop_detect_enable === 1'b1);
		wdt_expire = 1'b1;
		idle(1);
		wdt_expire = 1'b0;
		idle(2);
		ex(`OPC_WDT_RESTART);
		ck(skip_next === 1'b1 && watchdog_flag === 1'b0);
		ex(`OPC_WDT_RESTART);
		ck(skip_next === 1'b0);
		ex(`OPC_WDT_ARM);
		ex(`OPC_NOP);
		ex(`OPC_WDT_RESTART);
		ck(watchdog_stopped === 1'b0);
		ex(`OPC_WDT_ARM);
		ex(`OPC_WDT_RESTART);
		ck(watchdog_stopped === 1'b1);
		ex(`OPC_POWER_ARM);
		ex(`OPC_NOP);
		ex(`OPC_POWER_OFF);
		ck(ram_backup === 1'b0);
		ex(`OPC_POWER_ARM);
		ex(`OPC_POWER_OFF);
		ck(ram_backup === 1'b1);
		ex(`OPC_REF_SET);
		ck(instr_taken === 1'b0 && upper_bit_ref_enable === 1'b0);
		rst_b = 1'b0;
		idle(2);
		ck(ram_backup === 1'b0 && watchdog_stopped === 1'b0 && comparator_reg === 8'h00);
		rst_b = 1'b1;
		summarize;
	end
endmodule : adc_and_system_instr_exec_test
bind adc_exec adc_exec_checker chk_i (.*);
